// ===== ccrs_pkg.sv
package ccrs_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned WORD_W = 18;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned ADDR_LO = 2;
  localparam int unsigned ADDR_HI = 21;
  localparam int unsigned MASK_W = 4;
  localparam int unsigned OPC_W = 2;
  localparam int unsigned WSEL_BIT = 1;
  localparam int unsigned NGROUP = 2;
  // ==========================================================
  // Cycle sources
  localparam logic [1:0] SRC_PROC = 2'h0;
  localparam logic [1:0] SRC_MAP = 2'h1;
  localparam logic [1:0] SRC_CHAN = 2'h2;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned DESKEW_NS = 100;
  localparam int unsigned DESKEW_CYC = (DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DCNT_W = 4;
  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 18'h0_0000;
  localparam logic [DCNT_W-1:0] DCNT_RST = 4'h0;
  // ==========================================================
  // Cycle sequence, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_TS1 = 10'h002,
    ST_TS2 = 10'h004,
    ST_TS3 = 10'h008,
    ST_TS4 = 10'h010,
    ST_HOLD = 10'h020,
    ST_WAIT = 10'h040,
    ST_SYNC = 10'h080,
    ST_RESTART = 10'h100,
    ST_DONE = 10'h200
  } ccrs_state_e;
endpackage

// ===== ccrs_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Hit in group one delivers group one's stored word as read data.
// - Hit in group zero delivers group zero's stored word as read data.
// - Each group outputs even or odd word chosen by word select bit.
// - Read miss with word select zero returns memory's even word.
// - Read miss with word select one returns memory's odd word.
// - Non-channel read miss inverts memory data and parity to array polarity.
// - Processor reads get the processor data strobe when data is ready.
// - Map reads get the map completion signal when data is ready.
// - Single clock; arbitration edge and inverted edge become successive stages.
// - Lock starts one sequence; blocked while request, two, four or hold active.
// - States advance one, two, three, four, hold on successive edges.
// - Hold stays until main request or cycle complete; decides memory need.
// - Read hit sets cycle complete at first hold edge where go-ahead allows, clearing lock.
// - Hit strobe at hold start if go-ahead seen, else when it arrives.
// - Address, byte masks, operation code and parity driven at cycle start.
// - Write launch waits for free data lines and gates write data out.
// - Bus start follows request and launch after deskew; ack withdraws it.
// - Reads hold write launch all cycle so start follows request by deskew.
// - Wait ends on ack; non-channel reads also need read data valid.
// - Array write pulse issues when waiting for memory ends.
// - Wait end passes sync stages into slow strobe and restart.
module ccrs_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  // Cycle request
  input wire logic I_LOCK,
  input wire logic [1:0] I_CYCLE_SRC,
  input wire logic I_IS_WRITE,
  input wire logic [ccrs_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [ccrs_pkg::MASK_W-1:0] I_BYTE_MASK,
  input wire logic [ccrs_pkg::OPC_W-1:0] I_OP_CODE,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_WRITE_DATA,
  input wire logic I_GO_AHEAD,
  // Tag compare and data array
  input wire logic I_HIT_G0,
  input wire logic I_HIT_G1,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_G0_EVEN,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_G0_ODD,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_G1_EVEN,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_G1_ODD,
  // Main memory bus inputs
  input wire logic I_BUS_BUSY,
  input wire logic I_ADDR_ACK,
  input wire logic I_READ_DATA_VALID,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_MAIN_EVEN,
  input wire logic [ccrs_pkg::WORD_W-1:0] I_MAIN_ODD,
  // Read data and completion
  output logic [ccrs_pkg::WORD_W-1:0] O_READ_DATA,
  output logic O_PROC_STROBE,
  output logic O_MAP_DONE,
  output logic O_CYCLE_DONE,
  output logic O_ARRAY_WP,
  output logic O_LOCK,
  // Main memory bus outputs
  output logic [ccrs_pkg::ADDR_HI:ccrs_pkg::ADDR_LO] O_BUS_ADDR,
  output logic [ccrs_pkg::MASK_W-1:0] O_BUS_MASK,
  output logic [ccrs_pkg::OPC_W-1:0] O_BUS_OPCODE,
  output logic O_BUS_ADDR_PAR,
  output logic O_MAIN_REQ,
  output logic O_WRITE_LAUNCH,
  output logic O_BUS_START,
  output logic [ccrs_pkg::WORD_W-1:0] O_BUS_WDATA,
  output logic O_BUS_WDATA_OE
);
  import ccrs_pkg::*;

  // ==========================================================
  // Declarations
  ccrs_state_e state_r;
  ccrs_state_e state_nxt;
  logic lock_r;
  logic [1:0] src_r;
  logic wr_r;
  logic wsel_r;
  logic hit0_r;
  logic hit1_r;
  logic go_seen_r;
  logic main_req_r;
  logic launch_r;
  logic start_r;
  logic ack_seen_r;
  logic rdv_seen_r;
  logic [DCNT_W-1:0] dcnt_r;
  logic [WORD_W-1:0] miss_even_r;
  logic [WORD_W-1:0] miss_odd_r;
  logic [WORD_W-1:0] rdata_r;
  logic pstb_r;
  logic mdone_r;
  logic done_r;
  logic wp_r;
  logic [ADDR_HI:ADDR_LO] baddr_r;
  logic [MASK_W-1:0] bmask_r;
  logic [OPC_W-1:0] bopc_r;
  logic bpar_r;
  logic [WORD_W-1:0] wdata_r;
  logic wdoe_r;
  wire [WORD_W-1:0] grp_even [NGROUP];
  wire [WORD_W-1:0] grp_odd [NGROUP];
  wire [WORD_W-1:0] grp_word [NGROUP];

  // ==========================================================
  // Group word select
  assign grp_even[0] = I_G0_EVEN;
  assign grp_odd[0] = I_G0_ODD;
  assign grp_even[1] = I_G1_EVEN;
  assign grp_odd[1] = I_G1_ODD;
  for (genvar g = 0; g < NGROUP; g++) begin : g_grp
    assign grp_word[g] = wsel_r ? grp_odd[g] : grp_even[g];
  end

  // ==========================================================
  // Decode
  wire is_proc = (src_r == SRC_PROC);
  wire is_map = (src_r == SRC_MAP);
  wire is_chan = (src_r == SRC_CHAN);
  wire any_hit = hit0_r | hit1_r;
  wire read_hit = ~wr_r & any_hit;
  wire need_main = wr_r | ~any_hit;
  wire go_ok = ~is_proc | go_seen_r | I_GO_AHEAD;
  wire in_hold = (state_r == ST_HOLD);
  wire in_ts2 = (state_r == ST_TS2) | (state_r == ST_TS3);
  wire in_ts4 = (state_r == ST_TS4);
  wire seq_block = main_req_r | in_ts2 | in_ts4 | in_hold;
  wire seq_go = (state_r == ST_IDLE) & I_LOCK & ~lock_r & ~seq_block;
  wire hit_finish = in_hold & read_hit & go_ok;
  wire miss_go = in_hold & need_main;
  wire need_data = ~wr_r & ~is_chan;
  wire ack_now = ack_seen_r | I_ADDR_ACK;
  wire rdv_now = rdv_seen_r | I_READ_DATA_VALID;
  wire wait_end = (state_r == ST_WAIT) & ack_now & (~need_data | rdv_now);
  wire deskew_done = (dcnt_r == DCNT_W'(DESKEW_CYC));
  wire launch_set = main_req_r & wr_r & ~I_BUS_BUSY;
  wire [WORD_W-1:0] main_even_pol = need_data ? ~I_MAIN_EVEN : I_MAIN_EVEN;
  wire [WORD_W-1:0] main_odd_pol = need_data ? ~I_MAIN_ODD : I_MAIN_ODD;
  wire [WORD_W-1:0] miss_word = wsel_r ? miss_odd_r : miss_even_r;
  wire [WORD_W-1:0] sel_word = hit1_r ? grp_word[1] :
                               hit0_r ? grp_word[0] :
                               miss_word;
  wire addr_par = ~^{I_ADDR[ADDR_HI:ADDR_LO], I_BYTE_MASK, I_OP_CODE};
  wire restart_rd = (state_r == ST_RESTART) & ~wr_r;

  // ==========================================================
  // Sequence
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (seq_go) begin
          state_nxt = ST_TS1;
        end
      end
      ST_TS1: state_nxt = ST_TS2;
      ST_TS2: state_nxt = ST_TS3;
      ST_TS3: state_nxt = ST_TS4;
      ST_TS4: state_nxt = ST_HOLD;
      ST_HOLD: begin
        if (hit_finish) begin
          state_nxt = ST_DONE;
        end else if (miss_go) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_end) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: state_nxt = ST_RESTART;
      ST_RESTART: state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Cycle capture and lock
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      lock_r <= 1'b0;
      src_r <= SRC_PROC;
      wr_r <= 1'b0;
      wsel_r <= 1'b0;
      baddr_r <= '0;
      bmask_r <= '0;
      bopc_r <= '0;
      bpar_r <= 1'b0;
      wdata_r <= WORD_RST;
    end else if (seq_go) begin
      lock_r <= 1'b1;
      src_r <= I_CYCLE_SRC;
      wr_r <= I_IS_WRITE;
      wsel_r <= I_ADDR[WSEL_BIT];
      baddr_r <= I_ADDR[ADDR_HI:ADDR_LO];
      bmask_r <= I_BYTE_MASK;
      bopc_r <= I_OP_CODE;
      bpar_r <= addr_par;
      wdata_r <= I_WRITE_DATA;
    end else if (state_r == ST_DONE) begin
      lock_r <= 1'b0;
    end
  end

  // ==========================================================
  // Hit and go-ahead capture
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | seq_go) begin
      go_seen_r <= 1'b0;
    end else if (I_GO_AHEAD & lock_r) begin
      go_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | seq_go) begin
      hit0_r <= 1'b0;
      hit1_r <= 1'b0;
    end else if (in_ts4) begin
      hit0_r <= I_HIT_G0;
      hit1_r <= I_HIT_G1;
    end
  end

  // ==========================================================
  // Main memory cycle control
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | (state_r == ST_DONE)) begin
      main_req_r <= 1'b0;
    end else if (miss_go) begin
      main_req_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | (state_r == ST_DONE)) begin
      launch_r <= 1'b0;
    end else if (seq_go & ~I_IS_WRITE) begin
      launch_r <= 1'b1;
    end else if (launch_set) begin
      launch_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | ~(main_req_r & launch_r)) begin
      dcnt_r <= DCNT_RST;
    end else if (~deskew_done) begin
      dcnt_r <= dcnt_r + 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | (state_r == ST_DONE)) begin
      ack_seen_r <= 1'b0;
      rdv_seen_r <= 1'b0;
    end else if (state_r == ST_WAIT) begin
      ack_seen_r <= ack_now;
      rdv_seen_r <= rdv_now;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | I_ADDR_ACK | ack_seen_r | ~main_req_r) begin
      start_r <= 1'b0;
    end else if (deskew_done & launch_r) begin
      start_r <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST | (state_r == ST_DONE)) begin
      wdoe_r <= 1'b0;
    end else if (launch_set) begin
      wdoe_r <= 1'b1;
    end
  end

  // ==========================================================
  // Memory data capture
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      miss_even_r <= WORD_RST;
      miss_odd_r <= WORD_RST;
    end else if ((state_r == ST_WAIT) & I_READ_DATA_VALID & ~wr_r) begin
      miss_even_r <= main_even_pol;
      miss_odd_r <= main_odd_pol;
    end
  end

  // ==========================================================
  // Read data and strobes
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      rdata_r <= WORD_RST;
      pstb_r <= 1'b0;
      mdone_r <= 1'b0;
      done_r <= 1'b0;
      wp_r <= 1'b0;
    end else begin
      if (hit_finish | (state_r == ST_SYNC)) begin
        rdata_r <= sel_word;
      end
      pstb_r <= (hit_finish & is_proc) | (restart_rd & is_proc);
      mdone_r <= (hit_finish & is_map) | (restart_rd & is_map);
      done_r <= (state_nxt == ST_DONE);
      wp_r <= wait_end;
    end
  end

  // ==========================================================
  // Outputs
  assign O_READ_DATA = rdata_r;
  assign O_PROC_STROBE = pstb_r;
  assign O_MAP_DONE = mdone_r;
  assign O_CYCLE_DONE = done_r;
  assign O_ARRAY_WP = wp_r;
  assign O_LOCK = lock_r;
  assign O_BUS_ADDR = baddr_r;
  assign O_BUS_MASK = bmask_r;
  assign O_BUS_OPCODE = bopc_r;
  assign O_BUS_ADDR_PAR = bpar_r;
  assign O_MAIN_REQ = main_req_r;
  assign O_WRITE_LAUNCH = launch_r;
  assign O_BUS_START = start_r;
  assign O_BUS_WDATA = wdata_r;
  assign O_BUS_WDATA_OE = wdoe_r;
endmodule

// ===== ccrs_mem_model.sv
`timescale 1ns/1ps
module ccrs_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus side
  input wire logic i_start,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic o_valid,
  output logic [ccrs_pkg::WORD_W-1:0] o_even,
  output logic [ccrs_pkg::WORD_W-1:0] o_odd
);
  import ccrs_pkg::*;
  localparam logic [WORD_W-1:0] M_EV = 18'h1_2345;
  localparam logic [WORD_W-1:0] M_OD = 18'h2_6abc;
  logic [3:0] cnt_r;
  logic served_r;
  logic [WORD_W-1:0] pat_r;
  // ==========================================================
  // One answer per start, after i_lat cycles
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 4'h0;
      served_r <= 1'b0;
      o_ack <= 1'b0;
      o_valid <= 1'b0;
      pat_r <= 18'h0_0000;
    end else begin
      pat_r <= ~pat_r;
      o_ack <= 1'b0;
      o_valid <= 1'b0;
      if (!i_start) begin
        served_r <= 1'b0;
      end else if (!served_r && cnt_r == i_lat) begin
        o_ack <= 1'b1;
        o_valid <= 1'b1;
        served_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (!served_r) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
  // Bus polarity is inverted; lines toggle when not valid
  assign o_even = o_valid ? ~M_EV : pat_r;
  assign o_odd = o_valid ? ~M_OD : ~pat_r;
endmodule

// ===== ccrs_chk_sva.sv
`timescale 1ns/1ps
module ccrs_chk (
  // Watched ports
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_ADDR_ACK,
  input wire logic I_BUS_BUSY,
  input wire logic O_LOCK,
  input wire logic O_CYCLE_DONE,
  input wire logic O_ARRAY_WP,
  input wire logic [ccrs_pkg::ADDR_HI:ccrs_pkg::ADDR_LO] O_BUS_ADDR,
  input wire logic [ccrs_pkg::MASK_W-1:0] O_BUS_MASK,
  input wire logic [ccrs_pkg::OPC_W-1:0] O_BUS_OPCODE,
  input wire logic O_BUS_ADDR_PAR,
  input wire logic O_MAIN_REQ,
  input wire logic O_WRITE_LAUNCH,
  input wire logic O_BUS_START,
  input wire logic O_BUS_WDATA_OE
);
  import ccrs_pkg::*;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ==========================================================
  // Assertions
  chk_start_deskew: assert property ($rose(O_BUS_START) |->
    $past(O_MAIN_REQ, 12) && $past(O_WRITE_LAUNCH, 12)) else $error("bus start too early");
  chk_ack_clears: assert property (O_BUS_START && I_ADDR_ACK |=> !O_BUS_START)
    else $error("bus start kept after ack");
  chk_launch_free: assert property ($rose(O_WRITE_LAUNCH) && $past(O_MAIN_REQ)
    |-> !$past(I_BUS_BUSY)) else $error("launch while lines busy");
  chk_oe_launch: assert property (O_BUS_WDATA_OE |-> O_WRITE_LAUNCH)
    else $error("write data driven without launch");
  chk_min_hit: assert property ($rose(O_LOCK) |-> !O_CYCLE_DONE [*5])
    else $error("cycle done before hold");
  chk_wp_done: assert property ($rose(O_ARRAY_WP) |-> ##2 O_CYCLE_DONE)
    else $error("done not two cycles after write pulse");
  chk_wp_main: assert property (O_ARRAY_WP |-> O_MAIN_REQ)
    else $error("write pulse without main cycle");
  chk_done_unlock: assert property (O_CYCLE_DONE |-> O_LOCK ##1 (!O_LOCK && !O_CYCLE_DONE))
    else $error("lock held at done");
  chk_addr_par: assert property (O_LOCK |->
    O_BUS_ADDR_PAR == ~^{O_BUS_ADDR, O_BUS_MASK, O_BUS_OPCODE}) else $error("bad parity");
endmodule
bind ccrs_top ccrs_chk u_ccrs_chk (.*);

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ccrs_pkg::*;
  localparam logic [WORD_W-1:0] M_EV = 18'h1_2345;
  localparam logic [WORD_W-1:0] M_OD = 18'h2_6abc;
  localparam logic [WORD_W-1:0] M_EV_BUS = ~M_EV;
  logic I_CORE_CLK = 0, I_SYS_RST = 1, I_LOCK = 0, I_IS_WRITE = 0, I_GO_AHEAD = 0;
  logic I_HIT_G0 = 0, I_HIT_G1 = 0, I_BUS_BUSY = 0, I_ADDR_ACK, I_READ_DATA_VALID;
  logic [1:0] I_CYCLE_SRC = 0, I_OP_CODE = 0;
  logic [ADDR_W-1:0] I_ADDR = 0;
  logic [MASK_W-1:0] I_BYTE_MASK = 0;
  logic [WORD_W-1:0] I_WRITE_DATA = 0, I_MAIN_EVEN, I_MAIN_ODD, O_READ_DATA, O_BUS_WDATA;
  logic [WORD_W-1:0] I_G0_EVEN = 18'h0_1111, I_G0_ODD = 18'h0_2222;
  logic [WORD_W-1:0] I_G1_EVEN = 18'h0_3333, I_G1_ODD = 18'h0_4444;
  logic O_PROC_STROBE, O_MAP_DONE, O_CYCLE_DONE, O_ARRAY_WP, O_LOCK, O_BUS_ADDR_PAR;
  logic O_MAIN_REQ, O_WRITE_LAUNCH, O_BUS_START, O_BUS_WDATA_OE;
  logic [ADDR_HI:ADDR_LO] O_BUS_ADDR;
  logic [MASK_W-1:0] O_BUS_MASK;
  logic [OPC_W-1:0] O_BUS_OPCODE;
  logic [3:0] lat = 0;
  int n_fail = 0, n_checks = 0, cyc = 0, sc, ps, md, wd;
  always #4 I_CORE_CLK = ~I_CORE_CLK;
  ccrs_top u_ccrs_top (.*);
  ccrs_mem_model u_ccrs_mem_model (.i_clk(I_CORE_CLK), .i_rst(I_SYS_RST),
    .i_start(O_BUS_START), .i_lat(lat), .o_ack(I_ADDR_ACK), .o_valid(I_READ_DATA_VALID),
    .o_even(I_MAIN_EVEN), .o_odd(I_MAIN_ODD));
  // ==========================================================
  // Shared tasks
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge I_CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic run(logic [1:0] src, logic wr, logic [ADDR_W-1:0] a, logic h0, h1, go);
    if (O_LOCK === 1'b1) @(negedge I_CORE_CLK);
    I_CYCLE_SRC = src;
    I_IS_WRITE = wr;
    I_ADDR = a;
    I_BYTE_MASK = a[5:2];
    I_OP_CODE = a[7:6];
    I_HIT_G0 = h0;
    I_HIT_G1 = h1;
    I_GO_AHEAD = go;
    I_LOCK = 1;
    @(negedge I_CORE_CLK) I_LOCK = 0;
    sc = 0;
    ps = 0;
    md = 0;
    wd = 0;
    for (int i = 1; i < 200; i++) begin
      @(negedge I_CORE_CLK);
      if (i == 9) I_GO_AHEAD = 1;
      if (i == 20) I_BUS_BUSY = 0;
      if (i == 2) chk("bus", {~^{a[21:2], a[5:2], a[7:6]}, a[21:2], a[5:2], a[7:6]},
        {O_BUS_ADDR_PAR, O_BUS_ADDR, O_BUS_MASK, O_BUS_OPCODE});
      if (O_PROC_STROBE === 1'b1) begin
        ps++;
        sc = i;
      end
      if (O_MAP_DONE === 1'b1) md++;
      if (O_BUS_WDATA_OE === 1'b1) wd = 1;
      if (O_BUS_WDATA_OE === 1'b1) chk("wdata", I_WRITE_DATA, O_BUS_WDATA);
      if (O_CYCLE_DONE === 1'b1) break;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_hit;
    for (int k = 0; k < 4; k++) begin
      run(SRC_PROC, 0, {19'h5_a5c3, 2'(k), 1'b0}, !k[1], k[1], 1);
      chk("rdata", k[1] ? (k[0] ? I_G1_ODD : I_G1_EVEN) : (k[0] ? I_G0_ODD : I_G0_EVEN),
        O_READ_DATA);
      chk("strobe", 32'h0000_0105, {ps[23:0], sc[7:0]});
    end
    run(SRC_PROC, 0, 22'h01_2340, 1, 0, 0);
    chk("late", 32'h0000_010a, {ps[23:0], sc[7:0]});
  endtask
  task automatic t_map;
    run(SRC_MAP, 0, 22'h2a_0002, 0, 1, 1);
    chk("map", 32'h0000_0100, {md[23:0], ps[7:0]});
    chk("mdata", I_G1_ODD, O_READ_DATA);
    run(SRC_CHAN, 0, 22'h15_0000, 1, 0, 1);
    chk("chan", 32'h0, {md[15:0], ps[15:0]});
    chk("cdata", I_G0_EVEN, O_READ_DATA);
  endtask
  task automatic t_miss;
    for (int k = 0; k < 3; k++) begin
      lat = k ? 4'h5 : 4'h0;
      run(k[1] ? SRC_CHAN : SRC_PROC, 0, {20'h3_a5c3, k[0], 1'b0}, 0, 0, 1);
      chk("miss", k[1] ? M_EV_BUS : (k[0] ? M_OD : M_EV), O_READ_DATA);
      chk("mstrb", !k[1], ps);
    end
  endtask
  task automatic t_write;
    I_BUS_BUSY = 1;
    I_WRITE_DATA = 18'h2_b00c;
    lat = 4'h3;
    run(SRC_PROC, 1, 22'h15_5554, 1, 0, 1);
    chk("oe", 1, wd);
    @(negedge I_CORE_CLK);
    chk("lock", 0, O_LOCK);
  endtask
  initial begin
    repeat (4) @(posedge I_CORE_CLK);
    @(negedge I_CORE_CLK) I_SYS_RST = 0;
    chk("idle", 0, {O_LOCK, O_MAIN_REQ, O_BUS_START, O_CYCLE_DONE, O_BUS_WDATA_OE});
    t_hit();
    t_map();
    t_miss();
    t_write();
    stop_test();
  end
endmodule
